// *** adda_pkg.sv ***
// constants and types shared by the address decode and dram arbitration block
// assumes a single system clock; included by package reference only
package adda_pkg;
	localparam logic [11:0] REG_PAGE = 12'hfff; // register block page, address bits 23..12
	localparam logic [11:0] OFS_MAP = 12'h000; // relocation register
	localparam logic [11:0] OFS_CTRL = 12'h002; // map mode and dram bank enables
	localparam logic [11:0] OFS_STAT = 12'h004; // read-only arbiter status
	localparam logic [3:0] RELOC_RST = 4'h0;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam int CTRL_MAP256 = 15; // bit position: 256M map enable
	localparam int CS_MIN_SH = 18; // 256K smallest chip-select region
	localparam int DR_MIN_SH = 19; // 512K smallest dram region
	localparam int TIM_SET = 0; // timing field positions, read half
	localparam int TIM_ACC = 2;
	localparam int TIM_HOLD = 4;
	localparam int TIM_REC = 6;
	localparam logic [2:0] FPM_3 = 3'h3; // fast page access lengths in clocks
	localparam logic [2:0] FPM_4 = 3'h4;
	localparam logic [2:0] FPM_5 = 3'h5;
	localparam logic [2:0] REF_LEN = 3'h4; // refresh cycle length in clocks
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CS_SET = 3'b001,
		ST_CS_ACC = 3'b010,
		ST_CS_HOLD = 3'b011,
		ST_CS_REC = 3'b100,
		ST_DR_WAIT = 3'b101
	} adda_core_t;
	typedef enum logic [1:0] {
		D_IDLE = 2'b00,
		D_RUN = 2'b01,
		D_REF = 2'b10
	} adda_dram_t;
endpackage : adda_pkg

// *** adda_top.sv ***
// address decode, chip-select sequencing and dram arbitration
// assumes core request fields stay stable until core_ack_o, and that the
// outer register file answers reg_rdata_i combinationally from core_addr_i
// What this block does
// R1: decode one contiguous 4K block of control and status registers.
// R2: after reset the 16M map places registers at 0x00FFF000..0x00FFFFFF.
// R3: register reads and writes finish in one bus cycle, no wait states.
// R4: masters access registers only as aligned 16-bit words.
// R5: software may switch to a 256M map and move the register block up.
// R6: relocation register holds base bits 27..24, compared against the address.
// R7: overlap priority is registers, then chip-selects, then dram.
// R8: registers read and write, except a few read-only or write-only.
// R9: eight chip-select banks, 256K to 64M, placed anywhere in 256M.
// R10: each chip-select bank has its own size and disable.
// R11: chip-select cycles end internally; the wait input adds wait states.
// R12: per-bank setup, access, hold and recovery for reads and writes.
// R13: six dram banks, programmable size and place, row/column muxed, 512K to 32M each.
// R14: all dram banks are disabled at reset.
// R15: fast page dram access takes 3, 4 or 5 clocks.
// R16: cas-before-ras refresh at a programmable rate, running from reset.
// R17: graphics unit wins dram over the core when both ask.
// R18: one-word write buffer takes core dram writes without waits.
// R19: core fetches on the processor bus never touch graphics traffic.
// R20: the relocation field resets to zero.
`timescale 1ns/1ps
module adda_top (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic core_req_i,
	input wire logic core_we_i,
	input wire logic [27:0] core_addr_i,
	input wire logic [15:0] core_wdata_i,
	output logic core_ack_o,
	output logic [15:0] core_rdata_o,
	input wire logic [15:0] reg_rdata_i,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [11:0] reg_ofs_o,
	output logic [15:0] reg_wdata_o,
	input wire logic [79:0] cs_base_i,
	input wire logic [31:0] cs_size_i,
	input wire logic [7:0] cs_en_i,
	input wire logic [127:0] cs_tim_i,
	input wire logic wait_i,
	input wire logic [15:0] ext_rdata_i,
	output logic [7:0] cs_n_o,
	output logic oe_n_o,
	output logic we_n_o,
	input wire logic [53:0] dram_base_i,
	input wire logic [11:0] dram_size_i,
	input wire logic [1:0] dram_mode_i,
	input wire logic [11:0] ref_div_i,
	input wire logic gfx_req_i,
	output logic gfx_gnt_o,
	output logic [5:0] dram_ras_n_o,
	output logic dram_cas_n_o,
	output logic dram_we_n_o,
	output logic [10:0] dram_ma_o,
	output logic [15:0] dram_wdata_o,
	input wire logic [15:0] dram_rdata_i
);
	adda_pkg::adda_core_t st_reg, st_next;
	adda_pkg::adda_dram_t ds_reg, ds_next;
	logic [3:0] reloc_reg, reloc_next;
	logic [15:0] ctrl_reg, ctrl_next;
	logic [2:0] bank_reg, bank_next;
	logic [7:0] tim_reg, tim_next;
	logic [1:0] cnt_reg, cnt_next;
	logic wr_reg, wr_next;
	logic [2:0] w_reg, w_next;
	logic wf_reg, wf_next;
	logic [11:0] rc_reg, rc_next;
	logic rp_reg, rp_next, rd_reg, rd_next, wb_reg, wb_next;
	logic [2:0] wbb_reg, wbb_next, db_reg, db_next, dc_reg, dc_next;
	logic [21:0] wba_reg, wba_next, da_reg, da_next;
	logic [15:0] wbd_reg, wbd_next;
	logic ack_next, rw_next, rr_next, gnt_next, dwe_next, cas_next;
	logic [15:0] rdata_next;
	logic [7:0] cs_n_next;
	logic oe_next, we_next;
	logic [5:0] ras_next;
	logic [10:0] ma_next;
	logic [7:0] cs_hit;
	logic [5:0] dr_hit;
	logic reg_hit, dr_done;
	logic [2:0] cs_idx, dr_idx, dlen;
	logic [15:0] tsel;

	////////////////////////////////////////////////////////////////////////
	// region decode; lower bank numbers win among overlapping banks
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_cs
			logic [27:0] m;
			assign m = 28'hfffffff << (adda_pkg::CS_MIN_SH + cs_size_i[4*g+:4]);
			assign cs_hit[g] = cs_en_i[g] && (((core_addr_i ^ {cs_base_i[10*g+:10], 18'h0}) & m) == 28'h0); // R9 R10
		end
		for (g = 0; g < 6; g++) begin : g_dr
			logic [27:0] m;
			assign m = 28'hfffffff << (adda_pkg::DR_MIN_SH + 2 * dram_size_i[2*g+:2]);
			assign dr_hit[g] = ctrl_reg[g] && (((core_addr_i ^ {dram_base_i[9*g+:9], 19'h0}) & m) == 28'h0); // R13 R14
		end
	endgenerate

	// in the 16M map the top nibble is ignored, so the block mirrors there
	assign reg_hit = (core_addr_i[23:12] == adda_pkg::REG_PAGE) && // R1 R2
		(!ctrl_reg[adda_pkg::CTRL_MAP256] || core_addr_i[27:24] == reloc_reg); // R5 R6

	// priority encoders and per-access lookups
	always_comb begin
		cs_idx = 3'h0;
		dr_idx = 3'h0;
		for (int i = 7; i >= 0; i--) if (cs_hit[i]) cs_idx = 3'(i);
		for (int i = 5; i >= 0; i--) if (dr_hit[i]) dr_idx = 3'(i);
		tsel = cs_tim_i[16*cs_idx+:16];
		case (dram_mode_i)
			2'h0: dlen = adda_pkg::FPM_3; // R15
			2'h1: dlen = adda_pkg::FPM_4;
			default: dlen = adda_pkg::FPM_5;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state: dram engine first, then the core sequencer, then pins
	always_comb begin
		st_next = st_reg;
		ds_next = ds_reg;
		reloc_next = reloc_reg;
		ctrl_next = ctrl_reg;
		bank_next = bank_reg;
		tim_next = tim_reg;
		cnt_next = cnt_reg;
		wr_next = wr_reg;
		rd_next = rd_reg;
		wb_next = wb_reg;
		wbb_next = wbb_reg;
		wba_next = wba_reg;
		wbd_next = wbd_reg;
		db_next = db_reg;
		da_next = da_reg;
		dc_next = dc_reg;
		gnt_next = gfx_gnt_o;
		rdata_next = core_rdata_o;
		ack_next = 1'b0;
		rw_next = 1'b0;
		rr_next = 1'b0;
		dr_done = 1'b0;
		// three-flop input chain; a change counts once stages two and three agree
		w_next = {w_reg[1:0], wait_i};
		wf_next = (w_reg[1] == w_reg[2]) ? w_reg[2] : wf_reg;
		// refresh timer runs from reset whatever the enables say
		rc_next = (rc_reg == ref_div_i) ? 12'h000 : rc_reg + 12'h001; // R16
		rp_next = rp_reg | (rc_reg == ref_div_i); // R16
		case (ds_reg)
			adda_pkg::D_IDLE: begin
				if (gfx_gnt_o) begin
					gnt_next = gfx_req_i; // held until the graphics unit lets go
				end else if (rp_reg) begin
					ds_next = adda_pkg::D_REF; // R16
					dc_next = 3'h0;
					rp_next = rc_reg == ref_div_i;
				end else if (gfx_req_i) begin
					gnt_next = 1'b1; // R17
				end else if (wb_reg || rd_reg) begin
					ds_next = adda_pkg::D_RUN; // R18
					dc_next = 3'h0;
					db_next = wb_reg ? wbb_reg : dr_idx;
					da_next = wb_reg ? wba_reg : core_addr_i[22:1];
				end
			end
			adda_pkg::D_RUN: begin
				dc_next = dc_reg + 3'h1;
				if (dc_reg == dlen - 3'h1) begin
					ds_next = adda_pkg::D_IDLE;
					dc_next = 3'h0;
					dr_done = 1'b1;
					if (wb_reg) wb_next = 1'b0;
					else rd_next = 1'b0;
				end
			end
			adda_pkg::D_REF: begin
				dc_next = dc_reg + 3'h1;
				if (dc_reg == adda_pkg::REF_LEN - 3'h1) begin
					ds_next = adda_pkg::D_IDLE;
					dc_next = 3'h0;
				end
			end
			default: ds_next = adda_pkg::D_IDLE;
		endcase
		case (st_reg)
			adda_pkg::ST_IDLE: begin
				if (core_req_i) begin
					if (reg_hit) begin
						ack_next = 1'b1; // R3 R7
						rdata_next = 16'h0000;
						if (core_we_i) begin
							// status is read-only; map and ctrl are written here, all other offsets go out to the register file
							case (core_addr_i[11:0])
								adda_pkg::OFS_MAP: reloc_next = core_wdata_i[3:0]; // R6 R8
								adda_pkg::OFS_CTRL: ctrl_next = core_wdata_i; // R5
								adda_pkg::OFS_STAT: ;
								default: rw_next = 1'b1;
							endcase
						end else begin
							case (core_addr_i[11:0])
								adda_pkg::OFS_MAP: rdata_next = {12'h000, reloc_reg};
								adda_pkg::OFS_CTRL: rdata_next = ctrl_reg;
								adda_pkg::OFS_STAT: rdata_next = {9'h000, gfx_gnt_o, rp_reg, rd_reg, wb_reg, 1'b0, ds_reg};
								default: begin
									rdata_next = reg_rdata_i;
									rr_next = 1'b1;
								end
							endcase
						end
					end else if (|cs_hit) begin
						// fetches end here and never enter the dram arbiter
						st_next = adda_pkg::ST_CS_SET; // R7 R19
						bank_next = cs_idx;
						wr_next = core_we_i;
						tim_next = core_we_i ? tsel[15:8] : tsel[7:0]; // R12
						cnt_next = tim_next[adda_pkg::TIM_SET+:2];
					end else if (|dr_hit) begin
						st_next = adda_pkg::ST_DR_WAIT; // R7
						rd_next = !core_we_i;
					end else begin
						ack_next = 1'b1; // unmapped: zero data, no error
						rdata_next = 16'h0000;
					end
				end
			end
			adda_pkg::ST_CS_SET: begin
				cnt_next = cnt_reg - 2'h1;
				if (cnt_reg == 2'h0) begin
					st_next = adda_pkg::ST_CS_ACC;
					cnt_next = tim_reg[adda_pkg::TIM_ACC+:2];
				end
			end
			adda_pkg::ST_CS_ACC: begin
				if (cnt_reg != 2'h0) begin
					cnt_next = cnt_reg - 2'h1;
				end else if (!wf_reg) begin
					st_next = adda_pkg::ST_CS_HOLD; // R11
					cnt_next = tim_reg[adda_pkg::TIM_HOLD+:2];
					ack_next = 1'b1;
					rdata_next = ext_rdata_i;
				end
			end
			adda_pkg::ST_CS_HOLD: begin
				cnt_next = cnt_reg - 2'h1;
				if (cnt_reg == 2'h0) begin
					st_next = adda_pkg::ST_CS_REC;
					cnt_next = tim_reg[adda_pkg::TIM_REC+:2];
				end
			end
			adda_pkg::ST_CS_REC: begin
				cnt_next = cnt_reg - 2'h1;
				if (cnt_reg == 2'h0) st_next = adda_pkg::ST_IDLE;
			end
			adda_pkg::ST_DR_WAIT: begin
				if (core_we_i) begin
					if (!wb_reg) begin
						st_next = adda_pkg::ST_IDLE;
						ack_next = 1'b1;
					end
				end else if (dr_done && !wb_reg) begin
					st_next = adda_pkg::ST_IDLE;
					ack_next = 1'b1;
					rdata_next = dram_rdata_i;
				end
			end
			default: st_next = adda_pkg::ST_IDLE;
		endcase
		// a write that found the buffer free is parked and acknowledged at once
		if (core_we_i && !wb_reg && ((st_reg == adda_pkg::ST_IDLE && core_req_i && !reg_hit && !(|cs_hit) &&
			|dr_hit) || st_reg == adda_pkg::ST_DR_WAIT)) begin
			wb_next = 1'b1; // R18
			wbb_next = dr_idx;
			wba_next = core_addr_i[22:1];
			wbd_next = core_wdata_i;
			st_next = adda_pkg::ST_IDLE;
			ack_next = 1'b1;
		end
		// pins follow the state being entered so they leave flops directly
		cs_n_next = 8'hff;
		if (st_next == adda_pkg::ST_CS_SET || st_next == adda_pkg::ST_CS_ACC || st_next == adda_pkg::ST_CS_HOLD)
			cs_n_next = ~(8'h01 << bank_next);
		oe_next = !(st_next == adda_pkg::ST_CS_ACC && !wr_next);
		we_next = !(st_next == adda_pkg::ST_CS_ACC && wr_next);
		ras_next = 6'h3f;
		cas_next = 1'b1;
		dwe_next = 1'b1;
		ma_next = dram_ma_o;
		if (ds_next == adda_pkg::D_RUN) begin
			ras_next = ~(6'h01 << db_next); // R13
			cas_next = dc_next == 3'h0;
			dwe_next = !(wb_reg && dc_next != 3'h0);
			ma_next = (dc_next == 3'h0) ? da_next[21:11] : da_next[10:0];
		end else if (ds_next == adda_pkg::D_REF) begin
			cas_next = 1'b0; // R16
			ras_next = (dc_next == 3'h0) ? 6'h3f : 6'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state registers; a refresh tick is never lost to the clear beside it
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_reg <= adda_pkg::ST_IDLE;
			ds_reg <= adda_pkg::D_IDLE;
			reloc_reg <= adda_pkg::RELOC_RST; // R20
			ctrl_reg <= adda_pkg::CTRL_RST; // R14
			bank_reg <= 3'h0;
			tim_reg <= 8'h00;
			cnt_reg <= 2'h0;
			wr_reg <= 1'b0;
			w_reg <= 3'h0;
			wf_reg <= 1'b0;
			rc_reg <= 12'h000;
			rp_reg <= 1'b0;
			rd_reg <= 1'b0;
			wb_reg <= 1'b0;
			wbb_reg <= 3'h0;
			wba_reg <= 22'h0;
			wbd_reg <= 16'h0000;
			db_reg <= 3'h0;
			da_reg <= 22'h0;
			dc_reg <= 3'h0;
			core_ack_o <= 1'b0;
			core_rdata_o <= 16'h0000;
			reg_wr_o <= 1'b0;
			reg_rd_o <= 1'b0;
			reg_ofs_o <= 12'h000;
			reg_wdata_o <= 16'h0000;
			cs_n_o <= 8'hff;
			oe_n_o <= 1'b1;
			we_n_o <= 1'b1;
			gfx_gnt_o <= 1'b0;
			dram_ras_n_o <= 6'h3f;
			dram_cas_n_o <= 1'b1;
			dram_we_n_o <= 1'b1;
			dram_ma_o <= 11'h000;
			dram_wdata_o <= 16'h0000;
		end else begin
			st_reg <= st_next;
			ds_reg <= ds_next;
			reloc_reg <= reloc_next;
			ctrl_reg <= ctrl_next;
			bank_reg <= bank_next;
			tim_reg <= tim_next;
			cnt_reg <= cnt_next;
			wr_reg <= wr_next;
			w_reg <= w_next;
			wf_reg <= wf_next;
			rc_reg <= rc_next;
			rp_reg <= rp_next;
			rd_reg <= rd_next;
			wb_reg <= wb_next;
			wbb_reg <= wbb_next;
			wba_reg <= wba_next;
			wbd_reg <= wbd_next;
			db_reg <= db_next;
			da_reg <= da_next;
			dc_reg <= dc_next;
			core_ack_o <= ack_next;
			core_rdata_o <= rdata_next;
			reg_wr_o <= rw_next;
			reg_rd_o <= rr_next;
			reg_ofs_o <= core_addr_i[11:0];
			reg_wdata_o <= core_wdata_i;
			cs_n_o <= cs_n_next;
			oe_n_o <= oe_next;
			we_n_o <= we_next;
			gfx_gnt_o <= gnt_next;
			dram_ras_n_o <= ras_next;
			dram_cas_n_o <= cas_next;
			dram_we_n_o <= dwe_next;
			dram_ma_o <= ma_next;
			dram_wdata_o <= wbd_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	AST_REG_ACK: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // R3
		st_reg == adda_pkg::ST_IDLE && core_req_i && reg_hit |=> core_ack_o)
		else $error("register access not acknowledged next cycle");
	AST_PRIO: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // R7
		st_reg == adda_pkg::ST_IDLE && core_req_i && reg_hit |=> (cs_n_o == 8'hff) [*2])
		else $error("chip-select answered a register hit");
	AST_DRAM_OFF: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // R14
		st_reg == adda_pkg::ST_IDLE && core_req_i && !reg_hit && cs_hit == 8'h0 && ctrl_reg[5:0] == 6'h0
		|=> core_ack_o && core_rdata_o == 16'h0000)
		else $error("disabled dram answered");
	AST_GFX_FIRST: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // R17
		ds_reg == adda_pkg::D_IDLE && !gfx_gnt_o && !rp_reg && gfx_req_i && (wb_reg || rd_reg)
		|=> gfx_gnt_o && ds_reg == adda_pkg::D_IDLE)
		else $error("core won dram over graphics");
	AST_WB_NOWAIT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // R18
		st_reg == adda_pkg::ST_IDLE && core_req_i && core_we_i && !reg_hit && cs_hit == 8'h0 && dr_hit != 6'h0
		&& !wb_reg |=> core_ack_o && wb_reg)
		else $error("buffered write was not immediate");
	AST_WB_HOLD: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // R18
		wb_reg && gfx_gnt_o |=> wb_reg && dram_ras_n_o == 6'h3f)
		else $error("write buffer drained under graphics");
	AST_FPM3: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // R15
		$rose(ds_reg == adda_pkg::D_RUN) && dram_mode_i == 2'h0
		|-> (ds_reg == adda_pkg::D_RUN) [*3] ##1 ds_reg == adda_pkg::D_IDLE)
		else $error("fast page access not three clocks");
	AST_CBR: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // R16
		ds_reg == adda_pkg::D_IDLE && rp_reg && !gfx_gnt_o
		|=> !dram_cas_n_o && dram_ras_n_o == 6'h3f ##1 dram_ras_n_o == 6'h00)
		else $error("refresh not cas before ras");
	AST_WAIT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // R11
		st_reg == adda_pkg::ST_CS_ACC && wf_reg |=> st_reg == adda_pkg::ST_CS_ACC && !core_ack_o)
		else $error("wait input not honoured");
endmodule : adda_top

// *** adda_far_model.sv ***
// far side of the decode block: external memory, dram array, outer register file
// assumes the bench drives the stall request; the register word follows the address, everything else the strobes
`timescale 1ns/1ps
module adda_far_model (
	input wire logic clk_sys_i,
	input wire logic [7:0] cs_n_i,
	input wire logic oe_n_i,
	input wire logic [5:0] ras_n_i,
	input wire logic cas_n_i,
	input wire logic dwe_n_i,
	input wire logic [27:0] addr_i,
	input wire logic stall_i,
	output logic [15:0] ext_rdata_o,
	output logic [15:0] dram_rdata_o,
	output logic [15:0] reg_rdata_o,
	output logic wait_o
);
	logic [15:0] ext_last = 16'h0000;
	logic [15:0] dram_last = 16'h0000;
	////////////////////////////////////////////////////////////////////////////////
	// released buses show the inverse of their last value, so they toggle and a stale sample matches every other cycle
	assign ext_rdata_o = (cs_n_i != 8'hff && !oe_n_i) ? 16'hc5a3 : ~ext_last;
	assign dram_rdata_o = (ras_n_i != 6'h3f && !cas_n_i && dwe_n_i) ? 16'h3c96 : ~dram_last;
	always_ff @(posedge clk_sys_i) begin
		ext_last <= ext_rdata_o;
		dram_last <= dram_rdata_o;
	end
	// outer register word follows the address with no delay
	assign reg_rdata_o = {4'ha, addr_i[11:0]};
	// slow target holds the cycle open as long as the bench asks
	assign wait_o = stall_i;
endmodule : adda_far_model

// *** test_address_decode_and_dram_arbitration.sv ***
// self-checking bench for the address decode and dram arbitration block
// assumes adda_top and adda_far_model are compiled before it
`timescale 1ns/1ps
module test_address_decode_and_dram_arbitration;
	logic clk_sys_i = 1'b0, nrst_i = 1'b0, core_req_i = 1'b0, core_we_i = 1'b0, stall = 1'b0, gfx_req_i = 1'b0;
	logic [27:0] core_addr_i = 28'h0000000;
	logic [15:0] core_wdata_i = 16'h0000, reg_rdata_i, ext_rdata_i, dram_rdata_i, rd, core_rdata_o, reg_wdata_o;
	logic [79:0] cs_base_i = 80'h0;
	logic [31:0] cs_size_i = 32'h0;
	logic [7:0] cs_en_i = 8'h00, cs_n_o, cs_seen;
	logic [127:0] cs_tim_i = 128'h0;
	logic [53:0] dram_base_i = 54'h0;
	logic [11:0] dram_size_i = 12'h000, ref_div_i = 12'h00f, reg_ofs_o;
	logic [1:0] dram_mode_i = 2'h0;
	logic wait_i, core_ack_o, reg_wr_o, reg_rd_o, oe_n_o, we_n_o, gfx_gnt_o, dram_cas_n_o, dram_we_n_o;
	logic [5:0] dram_ras_n_o;
	logic [10:0] dram_ma_o;
	logic [15:0] dram_wdata_o, dwr_data;
	logic [10:0] dwr_ma;
	logic [1:0] rpl;
	logic ras_seen, we_seen, gnt_seen, dwr_seen = 1'b0, ref_seen = 1'b0;
	int err_count = 0, n_checks = 0, cyc = 0, lat, l[4];
	adda_top uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .core_req_i(core_req_i), .core_we_i(core_we_i),
		.core_addr_i(core_addr_i), .core_wdata_i(core_wdata_i), .core_ack_o(core_ack_o), .core_rdata_o(core_rdata_o),
		.reg_rdata_i(reg_rdata_i), .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o), .reg_ofs_o(reg_ofs_o),
		.reg_wdata_o(reg_wdata_o), .cs_base_i(cs_base_i), .cs_size_i(cs_size_i), .cs_en_i(cs_en_i), .cs_tim_i(cs_tim_i),
		.wait_i(wait_i), .ext_rdata_i(ext_rdata_i), .cs_n_o(cs_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
		.dram_base_i(dram_base_i), .dram_size_i(dram_size_i), .dram_mode_i(dram_mode_i), .ref_div_i(ref_div_i),
		.gfx_req_i(gfx_req_i), .gfx_gnt_o(gfx_gnt_o), .dram_ras_n_o(dram_ras_n_o), .dram_cas_n_o(dram_cas_n_o),
		.dram_we_n_o(dram_we_n_o), .dram_ma_o(dram_ma_o), .dram_wdata_o(dram_wdata_o), .dram_rdata_i(dram_rdata_i));
	adda_far_model far (.clk_sys_i(clk_sys_i), .cs_n_i(cs_n_o), .oe_n_i(oe_n_o), .ras_n_i(dram_ras_n_o),
		.cas_n_i(dram_cas_n_o), .dwe_n_i(dram_we_n_o), .addr_i(core_addr_i), .stall_i(stall),
		.ext_rdata_o(ext_rdata_i), .dram_rdata_o(dram_rdata_i), .reg_rdata_o(reg_rdata_i), .wait_o(wait_i));
	////////////////////////////////////////////////////////////////////////////////
	// 4 ns clock
	initial begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	// strobe watchers and hang guard; the ceiling is well above the whole sequence
	always @(posedge clk_sys_i) begin
		if (dram_we_n_o === 1'b0 && dram_cas_n_o === 1'b0) begin
			dwr_seen <= 1'b1;
			dwr_data <= dram_wdata_o;
			dwr_ma <= dram_ma_o;
		end
		if (dram_cas_n_o === 1'b0 && dram_ras_n_o === 6'h00) ref_seen <= 1'b1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk_val
	task automatic chk_lat(input int got, input int lo, input int hi, input string m);
		n_checks++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("[FAIL] %0t %s cycles %0d", $time, m, got);
		end
	endtask : chk_lat
	// one core access; the request fields stand until the ack, then hold and recovery drain
	task automatic acc(input logic we, input logic [27:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		core_req_i <= 1'b1;
		core_we_i <= we;
		core_addr_i <= a;
		core_wdata_i <= d;
		@(posedge clk_sys_i);
		core_req_i <= 1'b0;
		lat = 1;
		{cs_seen, ras_seen, we_seen, gnt_seen} = '0;
		#1;
		// strobes are watched in the ack cycle too, so a one-cycle answer is still inspected
		forever begin
			cs_seen = cs_seen | ~cs_n_o;
			ras_seen = ras_seen | (dram_ras_n_o !== 6'h3f);
			we_seen = we_seen | (we_n_o === 1'b0);
			gnt_seen = gnt_seen | (gfx_gnt_o === 1'b1);
			if (core_ack_o === 1'b1 || lat >= 300) break;
			@(posedge clk_sys_i);
			#1;
			lat++;
		end
		rd = core_rdata_o;
		rpl = {reg_wr_o, reg_rd_o};
		repeat (10) @(posedge clk_sys_i);
	endtask : acc
	function automatic logic [27:0] ra(input logic [3:0] top, input logic [11:0] ofs);
		return {top, adda_pkg::REG_PAGE, ofs};
	endfunction : ra
	task automatic end_of_test();
		$display("errors %0d checks %0d", err_count, n_checks);
		if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////////////
	// reset state, refresh running before any setup, register access timing and kinds
	task automatic t_regs();
		chk_val({15'h0, ref_seen}, 16'h0001, "refresh after reset");
		ref_div_i <= 12'hfff;
		acc(1'b0, ra(4'h0, adda_pkg::OFS_MAP), 16'h0);
		chk_val(rd, 16'h0000, "reloc reset");
		chk_lat(lat, 1, 1, "reg read");
		acc(1'b0, ra(4'h0, adda_pkg::OFS_CTRL), 16'h0);
		chk_val(rd, 16'h0000, "ctrl reset");
		acc(1'b1, ra(4'h0, 12'hffe), 16'ha55a);
		chk_lat(lat, 1, 1, "top word write");
		chk_val({4'h0, reg_ofs_o}, 16'h0ffe, "outer offset");
		chk_val(reg_wdata_o, 16'ha55a, "outer wdata");
		chk_val({14'h0, rpl}, 16'h0002, "outer write strobe");
		acc(1'b0, ra(4'h0, 12'h010), 16'h0);
		chk_val(rd, 16'ha010, "outer read");
		chk_val({14'h0, rpl}, 16'h0001, "outer read strobe");
		acc(1'b1, ra(4'h0, adda_pkg::OFS_STAT), 16'hffff);
		chk_val({14'h0, rpl}, 16'h0000, "status write dropped");
		acc(1'b0, ra(4'h0, adda_pkg::OFS_STAT), 16'h0);
		chk_val(rd & 16'hffdc, 16'h0000, "status read only");
	endtask : t_regs
	// chip-select banks: size, disable, timing, wait, overlap priority
	task automatic t_cs();
		cs_base_i[19:0] <= {10'h03f, 10'h000};
		cs_size_i[11:0] <= 12'h220;
		cs_en_i <= 8'h07;
		cs_base_i[29:20] <= 10'h020;
		acc(1'b0, 28'h0000100, 16'h0);
		chk_lat(lat, 3, 3, "cs read timing 0");
		chk_val(rd, 16'hc5a3, "cs read data");
		acc(1'b0, ra(4'h0, 12'h010), 16'h0);
		chk_val({8'h0, cs_seen}, 16'h0000, "reg over cs");
		acc(1'b0, 28'h003fffe, 16'h0);
		chk_val({8'h0, cs_seen}, 16'h0001, "bank size top");
		acc(1'b0, 28'h0040000, 16'h0);
		chk_val({8'h0, cs_seen}, 16'h0000, "bank size beyond");
		cs_en_i <= 8'h06;
		acc(1'b0, 28'h0000100, 16'h0);
		chk_val({8'h0, cs_seen}, 16'h0000, "bank disabled");
		cs_en_i <= 8'h07;
		cs_tim_i[15:0] <= 16'h0409;
		acc(1'b0, 28'h0000100, 16'h0);
		chk_lat(lat, 6, 6, "read setup access");
		acc(1'b1, 28'h0000100, 16'h1111);
		chk_lat(lat, 4, 4, "write access");
		chk_val({15'h0, we_seen}, 16'h0001, "write strobe");
		cs_tim_i[15:0] <= 16'h0000;
		stall <= 1'b1;
		// the stall needs four edges through the synchroniser before the access phase is reached
		repeat (4) @(posedge clk_sys_i);
		fork
			acc(1'b0, 28'h0000100, 16'h0);
			begin
				repeat (10) @(posedge clk_sys_i);
				stall <= 1'b0;
			end
		join
		chk_lat(lat, 11, 16, "wait extends");
	endtask : t_cs
	// dram buffer, graphics priority, access lengths
	task automatic t_dram();
		dram_base_i[8:0] <= 9'h010;
		acc(1'b1, ra(4'h0, adda_pkg::OFS_CTRL), 16'h0001);
		acc(1'b0, 28'h0800000, 16'h0);
		chk_val({7'h0, ras_seen, cs_seen}, 16'h0004, "cs over dram");
		cs_en_i <= 8'h03;
		acc(1'b1, 28'h0800010, 16'hbeef);
		chk_lat(lat, 1, 1, "buffered write");
		chk_val(dwr_data, 16'hbeef, "drained data");
		chk_val({5'h0, dwr_ma}, 16'h0008, "drained column");
		gfx_req_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		dwr_seen = 1'b0;
		acc(1'b1, 28'h0800020, 16'h1234);
		chk_lat(lat, 1, 1, "write during graphics");
		repeat (20) @(posedge clk_sys_i);
		chk_val({14'h0, dwr_seen, gfx_gnt_o}, 16'h0001, "held while granted");
		gfx_req_i <= 1'b0;
		repeat (30) @(posedge clk_sys_i);
		chk_val(dwr_data, 16'h1234, "drained after release");
		fork
			acc(1'b0, 28'h0800000, 16'h0);
			begin
				repeat (2) @(posedge clk_sys_i);
				gfx_req_i <= 1'b1;
				repeat (12) @(posedge clk_sys_i);
				gfx_req_i <= 1'b0;
			end
		join
		chk_val({gnt_seen, rd[14:0]}, 16'hbc96, "graphics first");
		chk_lat(lat, 13, 40, "core waits");
		for (int m = 0; m < 4; m++) begin
			dram_mode_i <= m[1:0];
			acc(1'b0, 28'h0800002, 16'h0);
			l[m] = lat;
		end
		chk_lat(l[1] - l[0], 1, 1, "mode 4 clocks");
		chk_lat(l[2] - l[0], 2, 2, "mode 5 clocks");
		chk_lat(l[3] - l[2], 0, 0, "mode 3 code");
		dram_size_i[1:0] <= 2'h1;
		acc(1'b0, 28'h0900000, 16'h0);
		chk_val({15'h0, ras_seen}, 16'h0001, "dram 2M bank");
	endtask : t_dram
	// relocation into the 256M map; core cycles still run with graphics granted
	task automatic t_reloc();
		cs_en_i <= 8'h00;
		gfx_req_i <= 1'b1;
		acc(1'b1, ra(4'h0, adda_pkg::OFS_MAP), 16'h0003);
		acc(1'b1, ra(4'h0, adda_pkg::OFS_CTRL), 16'h8001);
		acc(1'b0, ra(4'h3, adda_pkg::OFS_MAP), 16'h0);
		chk_val(rd, 16'h0003, "relocated base");
		chk_lat(lat, 1, 1, "reg during graphics");
		acc(1'b0, ra(4'h0, adda_pkg::OFS_MAP), 16'h0);
		chk_val(rd, 16'h0000, "old place unmapped");
		acc(1'b0, ra(4'h3, 12'h020), 16'h0);
		chk_val({15'h0, gfx_gnt_o}, 16'h0001, "grant kept");
		gfx_req_i <= 1'b0;
	endtask : t_reloc
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (20) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		repeat (40) @(posedge clk_sys_i);
		t_regs();
		t_cs();
		t_dram();
		t_reloc();
		end_of_test();
	end
endmodule : test_address_decode_and_dram_arbitration
